//--- rx_free_buffer_flow_accounting.v
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "rxbuf_consts.vh"

module rx_free_buffer_flow_accounting (
  input  wire        I_CLOCK,
  input  wire        I_RST,
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [11:0] I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output reg         O_PREADY,
  output reg         O_PSLVERR,
  input  wire        I_FRAME_DONE,
  input  wire [2:0]  I_FRAME_CH,
  input  wire [15:0] I_FRAME_BUFS,
  output reg  [7:0]  O_LOW_FILTER,
  output reg  [7:0]  O_FLOW_CTRL,
  output reg         O_RX_FLOW_EN
);

  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam [11:0] LOW_ADDR   = `OFS_LOW_THRESH;
  localparam [11:0] CTRL_ADDR  = `OFS_MAC_CTRL;
  localparam [11:0] FLOW_BASE  = `OFS_FLOW_BASE;
  localparam [11:0] FREE_BASE  = `OFS_FREE_BASE;
  localparam [6:0]  FLOW_BLOCK = FLOW_BASE[11:5];
  localparam [6:0]  FREE_BLOCK = FREE_BASE[11:5];

  // Register kinds seen by the read path
  localparam [2:0]  KIND_NONE  = 3'h0;
  localparam [2:0]  KIND_LOW   = 3'h1;
  localparam [2:0]  KIND_CTRL  = 3'h2;
  localparam [2:0]  KIND_FLOW  = 3'h3;
  localparam [2:0]  KIND_FREE  = 3'h4;

  // Bus phases
  localparam [1:0]  PH_IDLE    = 2'b00;
  localparam [1:0]  PH_ACCESS  = 2'b01;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg  [7:0]   low_thresh_ff;
  reg  [31:0]  ctrl_ff;
  reg  [63:0]  flow_thresh_ff;
  reg  [127:0] free_count_ff;
  reg  [1:0]   phase_ff;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  reg  [7:0]   nxt_low_thresh;
  reg  [31:0]  nxt_ctrl;
  wire [63:0]  nxt_flow_thresh;
  wire [127:0] nxt_free_count;
  wire [7:0]   nxt_low_filter;
  wire [7:0]   nxt_flow_ctrl;
  reg  [31:0]  nxt_prdata;
  reg          nxt_pslverr;
  reg          nxt_pready;
  reg  [1:0]   nxt_phase;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire         setup;
  wire         wr_take;
  wire         aligned;
  wire         in_flow;
  wire         in_free;
  wire         is_low;
  wire         is_ctrl;
  wire         flow_en;
  wire [2:0]   sel_ch;
  wire [7:0]   sel_hot;
  wire [7:0]   frame_hot;
  reg  [2:0]   rd_kind;

  assign setup     = I_PSEL & ~I_PENABLE;
  // Writes commit only on the edge that completes the access
  assign wr_take   = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  assign aligned   = (I_PADDR[1:0] == 2'b00);
  assign in_flow   = (I_PADDR[11:5] == FLOW_BLOCK) & aligned;
  assign in_free   = (I_PADDR[11:5] == FREE_BLOCK) & aligned;
  assign is_low    = (I_PADDR == LOW_ADDR);
  assign is_ctrl   = (I_PADDR == CTRL_ADDR);
  assign flow_en   = ctrl_ff[`CTRL_RFLOWEN_BIT];
  assign sel_ch    = I_PADDR[4:2];
  assign sel_hot   = 8'h01 << sel_ch;
  assign frame_hot = 8'h01 << I_FRAME_CH;

  always @* begin
    rd_kind = KIND_NONE;
    if (is_low) begin
      rd_kind = KIND_LOW;
    end else if (is_ctrl) begin
      rd_kind = KIND_CTRL;
    end else if (in_flow) begin
      rd_kind = KIND_FLOW;
    end else if (in_free) begin
      rd_kind = KIND_FREE;
    end
  end

  // ----------------------------------------
  // Bus phase
  // ----------------------------------------
  always @* begin
    nxt_phase = PH_IDLE;
    case (phase_ff)
      PH_IDLE: begin
        if (setup) begin
          nxt_phase = PH_ACCESS;
        end
      end
      PH_ACCESS: begin
        // Ready is given once; a back-to-back setup starts from idle
        nxt_phase = PH_IDLE;
      end
      default: begin
        nxt_phase = PH_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Per-channel count and compare
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g = g + 1) begin : chan
      wire hit_free;
      wire hit_flow;
      wire hit_frame;

      assign hit_free  = wr_take & in_free & sel_hot[g];
      assign hit_flow  = wr_take & in_flow & sel_hot[g];
      assign hit_frame = I_FRAME_DONE & frame_hot[g];

      rxbuf_channel i_rxbuf_channel (
        .i_hit_free  (hit_free),
        .i_hit_flow  (hit_flow),
        .i_hit_frame (hit_frame),
        .i_wdata     (I_PWDATA[15:0]),
        .i_bufs      (I_FRAME_BUFS),
        .i_count     (free_count_ff[g*16 +: 16]),
        .i_flow      (flow_thresh_ff[g*8 +: 8]),
        .i_low       (low_thresh_ff),
        .i_flow_en   (flow_en),
        .o_count     (nxt_free_count[g*16 +: 16]),
        .o_flow      (nxt_flow_thresh[g*8 +: 8]),
        .o_low_hit   (nxt_low_filter[g]),
        .o_flow_hit  (nxt_flow_ctrl[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // Configuration writes
  // ----------------------------------------
  always @* begin
    nxt_low_thresh = low_thresh_ff;
    nxt_ctrl       = ctrl_ff;
    if (wr_take && is_low) begin
      nxt_low_thresh = I_PWDATA[7:0];
    end
    if (wr_take && is_ctrl) begin
      // Reserved bits stay zero whatever software writes
      nxt_ctrl = I_PWDATA & `CTRL_RW_MASK;
    end
  end

  // ----------------------------------------
  // Read path and response
  // ----------------------------------------
  always @* begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    nxt_pready  = (nxt_phase == PH_ACCESS);
    if (setup) begin
      case (rd_kind)
        KIND_LOW: begin
          nxt_prdata = {24'h000000, low_thresh_ff};
        end
        KIND_CTRL: begin
          nxt_prdata = ctrl_ff;
        end
        KIND_FLOW: begin
          nxt_prdata = {24'h000000, flow_thresh_ff[sel_ch*8 +: 8]};
        end
        KIND_FREE: begin
          nxt_prdata = {16'h0000, free_count_ff[sel_ch*16 +: 16]};
        end
        default: begin
          // Unmapped or misaligned: refused, reads as zero
          nxt_pslverr = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Bus response registers
  // ----------------------------------------
  // No wait states: ready stands in the first access cycle only
  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
      phase_ff  <= PH_IDLE;
    end else begin
      O_PREADY  <= nxt_pready;
      O_PRDATA  <= nxt_prdata;
      O_PSLVERR <= nxt_pslverr;
      phase_ff  <= nxt_phase;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      low_thresh_ff  <= `RST_THRESH;
      ctrl_ff        <= `RST_CTRL;
      flow_thresh_ff <= {`NUM_CH{`RST_THRESH}};
    end else begin
      low_thresh_ff  <= nxt_low_thresh;
      ctrl_ff        <= nxt_ctrl;
      flow_thresh_ff <= nxt_flow_thresh;
    end
  end

  // ----------------------------------------
  // Free-buffer counters
  // ----------------------------------------
  // No saturation: software must keep its increments honest
  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      free_count_ff <= {`NUM_CH{`RST_COUNT}};
    end else begin
      free_count_ff <= nxt_free_count;
    end
  end

  // ----------------------------------------
  // Status outputs
  // ----------------------------------------
  // Levels lag the count by one edge so they never see a half-made sum
  always @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      O_LOW_FILTER <= 8'h00;
      O_FLOW_CTRL  <= 8'h00;
      O_RX_FLOW_EN <= 1'b0;
    end else begin
      O_LOW_FILTER <= nxt_low_filter;
      O_FLOW_CTRL  <= nxt_flow_ctrl;
      O_RX_FLOW_EN <= flow_en;
    end
  end

endmodule

// ----------------------------------------
// One receive channel: count and compares
// ----------------------------------------
module rxbuf_channel (
  input  wire        i_hit_free,
  input  wire        i_hit_flow,
  input  wire        i_hit_frame,
  input  wire [15:0] i_wdata,
  input  wire [15:0] i_bufs,
  input  wire [15:0] i_count,
  input  wire [7:0]  i_flow,
  input  wire [7:0]  i_low,
  input  wire        i_flow_en,
  output wire [15:0] o_count,
  output wire [7:0]  o_flow,
  output wire        o_low_hit,
  output wire        o_flow_hit
);

  wire [15:0] added;
  wire        low_under;
  wire        flow_under;

  // Increment and frame decrement in one cycle both apply; the
  // 16-bit sums wrap silently in either direction
  assign added      = i_hit_free ? i_count + i_wdata : i_count;
  assign o_count    = i_hit_frame ? added - i_bufs : added;
  assign o_flow     = i_hit_flow ? i_wdata[7:0] : i_flow;

  // A zero threshold never asserts; the settled count is compared
  assign low_under  = (i_low != 8'h00) && (i_count < {8'h00, i_low});
  assign flow_under = (i_flow != 8'h00) && (i_count < {8'h00, i_flow});
  assign o_low_hit  = low_under;
  assign o_flow_hit = i_flow_en & flow_under;

endmodule

//--- rxbuf_consts.vh
`ifndef RXBUF_CONSTS_VH
`define RXBUF_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_LOW_THRESH   12'h000
`define OFS_MAC_CTRL     12'h004
`define OFS_FLOW_BASE    12'h040
`define OFS_FREE_BASE    12'h080
`define ADDR_W           12

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define THRESH_W         8
`define COUNT_W          16
`define NUM_CH           8
`define CTRL_RFLOWEN_BIT 3
`define CTRL_RW_MASK     32'h0000_6a7b
`define RST_THRESH       8'h00
`define RST_COUNT        16'h0000
`define RST_CTRL         32'h0000_0000

`endif

//--- rxbuf_chk_asserts.sv
`timescale 1ns/100ps
module rxbuf_chk (
  input wire logic        I_CLOCK,
  input wire logic        I_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_FRAME_DONE,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic [7:0]  O_LOW_FILTER,
  input wire logic [7:0]  O_FLOW_CTRL,
  input wire logic        O_RX_FLOW_EN
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);
  rdy_next_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY) else $error("no ready");
  rdy_once_a: assert property (O_PREADY |=> !O_PREADY) else $error("long ready");
  rdy_access_a: assert property (O_PREADY |-> I_PSEL && I_PENABLE) else $error("stray ready");
  err_rdy_a: assert property (O_PSLVERR |-> O_PREADY) else $error("stray error");
  err_data_a: assert property (O_PSLVERR |-> O_PRDATA == 0) else $error("data on error");
  flow_off_a:
    assert property (!O_RX_FLOW_EN ##1 !O_RX_FLOW_EN |-> O_FLOW_CTRL == 0) else $error("flow off");
  filt_hold_a:
    assert property ((!I_FRAME_DONE && !I_PSEL) [*3] |-> $stable(O_LOW_FILTER)) else $error("filt");
  flow_hold_a:
    assert property ((!I_FRAME_DONE && !I_PSEL) [*3] |-> $stable(O_FLOW_CTRL)) else $error("flow");
endmodule
bind rx_free_buffer_flow_accounting rxbuf_chk i_chk (.*);

//--- testbench.sv
`timescale 1ns/100ps
`include "rxbuf_consts.vh"
module testbench;
  logic        I_CLOCK = 0, I_RST = 1, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0;
  logic        I_FRAME_DONE = 0, O_PREADY, O_PSLVERR, O_RX_FLOW_EN, err;
  logic [2:0]  I_FRAME_CH = 0;
  logic [7:0]  O_LOW_FILTER, O_FLOW_CTRL, lt, th [8];
  logic [11:0] I_PADDR = 0;
  logic [15:0] I_FRAME_BUFS = 0, cnt [8];
  logic [31:0] I_PWDATA = 0, O_PRDATA, rd;
  int          err_count, comparisons, cyc, ch, b;
  rx_free_buffer_flow_accounting i_rx_free_buffer_flow_accounting (.*);
  always #50 I_CLOCK = ~I_CLOCK;
  always @(posedge I_CLOCK) if (++cyc == 5000) begin err_count++; end_sim; end
  task chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin err_count++; $display("wrong value at %0t: %h, expected %h", $time, g, e); end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    I_PSEL <= 1; I_PWRITE <= w; I_PADDR <= a; I_PWDATA <= d;
    @(posedge I_CLOCK) I_PENABLE <= 1;
    do @(posedge I_CLOCK); while (O_PREADY !== 1);
    rd = O_PRDATA; err = O_PSLVERR; I_PSEL <= 0; I_PENABLE <= 0;
    @(posedge I_CLOCK);
  endtask
  function automatic logic [7:0] under(input bit f);
    for (int i = 0; i < 8; i++) under[i] = (f ? th[i] : lt) != 0 && cnt[i] < (f ? th[i] : lt);
  endfunction
  task end_sim;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    ch = $urandom(32'h2d8ae629);
    repeat (16) @(posedge I_CLOCK);
    I_RST <= 0;
    @(posedge I_CLOCK);
    apb(0, `OFS_MAC_CTRL, 0);
    chk(rd, 0);
    apb(0, 12'hffc, 0);
    chk(err, 1);
    chk(rd, 0);
    $display("reset and refusal test done");
    // Small counts so that the thresholds can bite
    for (int i = 0; i < 8; i++) begin
      cnt[i] = 16'($urandom_range(0, 300));
      th[i] = i ? 8'($urandom) : 8'h00;
      apb(1, `OFS_FREE_BASE + 12'(4 * i), 32'(cnt[i]));
      apb(1, `OFS_FREE_BASE + 12'(4 * i), 32'hffff);
      cnt[i] -= 16'h1;
      apb(0, `OFS_FREE_BASE + 12'(4 * i), 0);
      chk(rd, 32'(cnt[i]));
      apb(1, `OFS_FLOW_BASE + 12'(4 * i), 32'(th[i]));
    end
    $display("increment test done");
    lt = 8'($urandom);
    apb(1, `OFS_LOW_THRESH, 32'(lt));
    apb(1, `OFS_MAC_CTRL, 32'h8);
    repeat (40) begin
      ch = $urandom_range(0, 7);
      b = $urandom_range(0, 40);
      I_FRAME_CH <= 3'(ch); I_FRAME_BUFS <= 16'(b); I_FRAME_DONE <= 1;
      cnt[ch] -= 16'(b);
      @(posedge I_CLOCK) I_FRAME_DONE <= 0;
      repeat (2) @(posedge I_CLOCK);
      chk(O_LOW_FILTER, under(0));
      chk(O_FLOW_CTRL, under(1));
    end
    chk(O_RX_FLOW_EN, 1);
    for (int i = 0; i < 8; i++) begin
      apb(0, `OFS_FREE_BASE + 12'(4 * i), 0);
      chk(rd, 32'(cnt[i]));
    end
    // Replenish released buffers
    for (int i = 0; i < 8; i++) begin
      b = $urandom_range(0, 500);
      apb(1, `OFS_FREE_BASE + 12'(4 * i), 32'(b));
      cnt[i] += 16'(b);
      apb(0, `OFS_FREE_BASE + 12'(4 * i), 0);
      chk(rd, 32'(cnt[i]));
    end
    repeat (2) @(posedge I_CLOCK);
    chk(O_LOW_FILTER, under(0));
    chk(O_FLOW_CTRL, under(1));
    apb(1, `OFS_MAC_CTRL, 0);
    repeat (2) @(posedge I_CLOCK);
    chk(O_FLOW_CTRL, 0);
    chk(O_RX_FLOW_EN, 0);
    lt = 8'h00;
    apb(1, `OFS_LOW_THRESH, 32'(lt));
    repeat (2) @(posedge I_CLOCK);
    chk(O_LOW_FILTER, 0);
    $display("frame test done");
    end_sim;
  end
endmodule
